/* File: src/asr_pkg.sv */
/*
 * Shared constants, types and helpers for the serial readout sequencer.
 * Assumes a 100 MHz system clock; the times below are in nanoseconds.
 */
package asr_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int POR_TIME_NS   = 500000;
	localparam int CONV_TIME_NS  = 16600000;
	localparam int CONV_MAX_NS   = 21000000;
	// Least time rounds up
	localparam int POR_CYC       = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Nominal duration, well inside the 21 ms bound
	localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CONV_MAX_CYC  = CONV_MAX_NS / CLK_PERIOD_NS;
	localparam int CNT_W         = 22;

	// ------------------------------------------------------------------
	// Data
	// ------------------------------------------------------------------
	localparam int RES_W         = 16;
	localparam int RAW_W         = 18;
	localparam int BIT_CNT_W     = 4;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hF;
	localparam logic [RES_W-1:0] CODE_ZERO = 16'h0000;
	localparam logic [RES_W-1:0] CODE_FULL = 16'hFFFF;
	localparam int FIFO_DEPTH    = 16;

	typedef enum logic [1:0] {ST_POR, ST_CONVERT, ST_SLEEP, ST_OUTPUT} asr_state_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
	} asr_pins_t;

	// Clamp the signed raw core value into the 16-bit straight binary range
	function automatic logic [RES_W-1:0] asr_sat(input logic signed [RAW_W-1:0] raw);
		logic signed [RAW_W-1:0] full;
		full = RAW_W'($signed({2'b00, CODE_FULL}));
		if (raw < 0)
			return CODE_ZERO;
		else if (raw > full)
			return CODE_FULL;
		else
			return raw[RES_W-1:0];
	endfunction : asr_sat

endpackage : asr_pkg

/* File: src/asr_sequencer.sv */
/*
 * Conversion sequencer and 3-wire serial readout, with the result FIFO.
 * Assumes CS_N and SCK are asynchronous pins, the converter core sits on CLK,
 * and the pad logic resolves SERIAL_DATA_OUT from SDO_O and SDO_OE_N.
 */

`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Result FIFO
// ----------------------------------------------------------------------
module asr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	assign in_ready  = (count_reg != CW'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
			rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
			count_reg  <= CW'(count_reg + CW'(push) - CW'(pop));
		end
	end
endmodule : asr_fifo

// ----------------------------------------------------------------------
// Sequencer top
// ----------------------------------------------------------------------
module asr_sequencer
	import asr_pkg::*;
#(
	parameter int POR_CYCLES  = POR_CYC,
	parameter int CONV_CYCLES = CONV_CYC
) (
	input  wire logic                    CLK,
	input  wire logic                    RST,
	input  wire logic                    CS_N,
	input  wire logic                    SCK,
	input  wire logic signed [RAW_W-1:0] CONV_RAW,
	output logic                         SDO_O,
	output logic                         SDO_OE_N,
	output logic                         CONVERTING
);

	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------
	asr_pins_t pin_meta_reg;
	asr_pins_t pin_sync_reg;
	asr_pins_t pin_prev_reg;

	always_ff @(posedge CLK) begin
		pin_meta_reg <= '{cs_n: CS_N, sck: SCK};
		pin_sync_reg <= pin_meta_reg;
		pin_prev_reg <= pin_sync_reg;
	end

	wire cs_low   = ~pin_sync_reg.cs_n;
	wire sck_low  = ~pin_sync_reg.sck;
	wire cs_rise  = pin_sync_reg.cs_n & ~pin_prev_reg.cs_n;
	wire sck_fall = ~pin_sync_reg.sck & pin_prev_reg.sck;

	// ------------------------------------------------------------------
	// State and counters
	// ------------------------------------------------------------------
	asr_state_t           state_reg;
	asr_state_t           state_next;
	logic [CNT_W-1:0]     cnt_reg;
	logic [CNT_W-1:0]     cnt_next;
	logic [RES_W-1:0]     shift_reg;
	logic [RES_W-1:0]     shift_next;
	logic [BIT_CNT_W-1:0] bit_reg;
	logic [BIT_CNT_W-1:0] bit_next;
	logic                 sdo_next;

	logic [RES_W-1:0]     fifo_out;
	logic                 fifo_in_ready;
	logic                 fifo_out_valid;

	// Completion waits for buffer room, so a result is never dropped
	wire por_done   = (cnt_reg == CNT_W'(POR_CYCLES - 1));
	wire conv_done  = (cnt_reg >= CNT_W'(CONV_CYCLES - 1));
	wire push_res   = (state_reg == ST_CONVERT) & conv_done & fifo_in_ready;
	wire start_out  = (state_reg == ST_SLEEP) & cs_low & sck_low & fifo_out_valid;
	wire last_fall  = sck_fall & (bit_reg == LAST_BIT);
	wire out_abort  = (state_reg == ST_OUTPUT) & cs_rise;
	wire out_finish = (state_reg == ST_OUTPUT) & ~cs_rise & last_fall;
	wire [RES_W-1:0] sat_code = asr_sat(CONV_RAW);

	asr_fifo #(
		.WIDTH (RES_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst       (RST),
		.in_data   (sat_code),
		.in_valid  (push_res),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (start_out)
	);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		bit_next   = bit_reg;
		unique case (state_reg)
			ST_POR: begin
				cnt_next = CNT_W'(cnt_reg + 1'b1);
				if (por_done) begin
					state_next = ST_CONVERT;
					cnt_next   = '0;
				end
			end
			// Pins are not looked at here, so nothing can cut a conversion short
			ST_CONVERT: begin
				if (!conv_done)
					cnt_next = CNT_W'(cnt_reg + 1'b1);
				if (push_res)
					state_next = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (start_out) begin
					state_next = ST_OUTPUT;
					shift_next = fifo_out;
					bit_next   = '0;
				end
			end
			ST_OUTPUT: begin
				if (out_abort || out_finish) begin
					state_next = ST_CONVERT;
					cnt_next   = '0;
					shift_next = '0;
				end else if (sck_fall) begin
					shift_next = {shift_reg[RES_W-2:0], 1'b0};
					bit_next   = BIT_CNT_W'(bit_reg + 1'b1);
				end
			end
		endcase
	end

	// Status shows only in the convert and sleep states while selected
	always_comb begin
		unique case (state_next)
			ST_CONVERT: sdo_next = 1'b1;
			ST_SLEEP:   sdo_next = 1'b0;
			ST_OUTPUT:  sdo_next = shift_next[RES_W-1];
			ST_POR:     sdo_next = 1'b0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_reg  <= ST_POR;
			cnt_reg    <= '0;
			shift_reg  <= '0;
			bit_reg    <= '0;
			SDO_O      <= 1'b0;
			SDO_OE_N   <= 1'b1;
			CONVERTING <= 1'b0;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			shift_reg  <= shift_next;
			bit_reg    <= bit_next;
			SDO_O      <= sdo_next;
			SDO_OE_N   <= pin_sync_reg.cs_n;
			CONVERTING <= (state_next == ST_CONVERT);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_por_hold;
		(state_reg == ST_POR) && !por_done |=> (state_reg == ST_POR);
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("power-on interval ended early");

	property p_por_to_conv;
		(state_reg == ST_POR) ##1 (state_reg != ST_POR) |-> (state_reg == ST_CONVERT) && CONVERTING;
	endproperty
	a_por_to_conv: assert property (p_por_to_conv) else $error("no conversion after power-on");

	property p_sat;
		push_res |-> (CONV_RAW < 0 ? sat_code == CODE_ZERO :
			(CONV_RAW > 18'sh0FFFF ? sat_code == CODE_FULL : sat_code == CONV_RAW[RES_W-1:0]));
	endproperty
	a_sat: assert property (p_sat) else $error("result not saturated");

	property p_msb_first;
		start_out |=> (state_reg == ST_OUTPUT) && (SDO_O == shift_reg[RES_W-1]) && (bit_reg == '0);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("msb not presented on entry");

	property p_shift;
		(state_reg == ST_OUTPUT) && sck_fall && !cs_rise && !last_fall
			|=> shift_reg == {$past(shift_reg[RES_W-2:0]), 1'b0} && SDO_O == shift_reg[RES_W-1];
	endproperty
	a_shift: assert property (p_shift) else $error("bit not advanced on falling clock");

	property p_status_busy;
		(state_reg == ST_CONVERT) && (state_next == ST_CONVERT) |=> SDO_O;
	endproperty
	a_status_busy: assert property (p_status_busy) else $error("status not high while converting");

	property p_status_done;
		(state_reg == ST_SLEEP) && (state_next == ST_SLEEP) |=> !SDO_O;
	endproperty
	a_status_done: assert property (p_status_done) else $error("status not low after conversion");

	// The nominal count must never run past the worst-case limit
	property p_conv_bound;
		(state_reg == ST_CONVERT) |-> (cnt_reg < CNT_W'(CONV_MAX_CYC));
	endproperty
	a_conv_bound: assert property (p_conv_bound) else $error("conversion longer than its limit");

	property p_end_conv;
		out_abort || out_finish |=> (state_reg == ST_CONVERT) && (cnt_reg == '0);
	endproperty
	a_end_conv: assert property (p_end_conv) else $error("transfer end did not restart conversion");

	property p_oe;
		pin_sync_reg.cs_n |=> SDO_OE_N;
	endproperty
	a_oe: assert property (p_oe) else $error("output driven while deselected");

	property p_no_abort;
		(state_reg == ST_CONVERT) && !conv_done |=> (state_reg == ST_CONVERT);
	endproperty
	a_no_abort: assert property (p_no_abort) else $error("conversion cut short");

	property p_sleep_hold;
		(state_reg == ST_SLEEP) && !start_out |=> (state_reg == ST_SLEEP) && $stable(fifo_out);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep result changed");

	c_full_read:  cover property (out_finish);
	c_abort:      cover property (out_abort && bit_reg == '0);
	c_status_low: cover property ((state_reg == ST_SLEEP) && cs_low && !sck_low);

endmodule : asr_sequencer

`default_nettype wire

/* File: verif/asr_host.sv */
/*
 * Serial master model standing at the far side of the readout pins.
 * Assumes CLK at 100 MHz; SCK half period is 8 CLK, so the link runs at 160 ns.
 */
`timescale 1ns/100ps
`default_nettype none
module asr_host (
	input  wire logic clk,
	input  wire logic serial_data_out,
	output var logic  cs_n,
	output var logic  sck
);
	// ------------------------------------------------------------------
	// Pin sequencing
	// ------------------------------------------------------------------
	initial begin
		cs_n = 1'b1;
		sck  = 1'b1;
	end
	task automatic half();
		repeat (8) @(posedge clk);
	endtask : half
	// Clock stands at its idle level outside frames
	task automatic status();
		sck  <= 1'b1;
		cs_n <= 1'b0;
		half();
	endtask : status
	task automatic xfer(input logic hi, input int pulses, input logic last_fall, output logic [15:0] word);
		word = 16'h0000;
		sck  <= hi;
		half();
		cs_n <= 1'b0;
		half();
		for (int i = 0; i < pulses; i++) begin
			if (hi) begin
				sck <= 1'b0;
				half();
			end
			sck <= 1'b1;
			if (i < 16)
				word = {word[14:0], serial_data_out};
			half();
			if (!hi && (i < pulses - 1 || last_fall)) begin
				sck <= 1'b0;
				half();
			end
		end
	endtask : xfer
	task automatic release_cs();
		cs_n <= 1'b1;
		half();
	endtask : release_cs
endmodule : asr_host
`default_nettype wire

/* File: verif/asr_sequencer_bench.sv */
/*
 * Self-checking bench for the readout sequencer with a host model.
 * Assumes short power-on and conversion counts set through parameters.
 */
`timescale 1ns/100ps
`default_nettype none
module asr_sequencer_bench;
	import asr_pkg::*;
	localparam int POR_N  = 20;
	localparam int CONV_N = 100;
	typedef struct packed {
		logic signed [RAW_W-1:0] raw;
		logic                    hi;
		logic                    clk_end;
		logic [RES_W-1:0]        exp;
	} asr_row_t;
	asr_row_t rows [6] = '{
		'{18'sh0A5C3, 1'b1, 1'b0, 16'hA5C3},
		'{18'sh3FFFF, 1'b0, 1'b1, 16'h0000},
		'{18'sh10000, 1'b1, 1'b1, 16'hFFFF},
		'{18'sh0FFFF, 1'b0, 1'b0, 16'hFFFF},
		'{18'sh08001, 1'b1, 1'b1, 16'h8001},
		'{18'sh20000, 1'b0, 1'b0, 16'h0000}};
	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	logic signed [RAW_W-1:0] raw = 18'sh00000;
	wire logic               cs_n, sck, sdo_o, sdo_oe_n, conv, sdo_line;
	int                      miscompares = 0;
	int                      check_count = 0;
	int                      cycles = 0;
	int                      conv_run = 0;
	int                      conv_len_seen = 0;
	// Released line shows the inverse, so a floating read never passes
	assign sdo_line = sdo_oe_n ? ~sdo_o : sdo_o;
	asr_sequencer #(.POR_CYCLES(POR_N), .CONV_CYCLES(CONV_N)) asr_sequencer_i (.CLK(clk), .RST(rst),
		.CS_N(cs_n), .SCK(sck), .CONV_RAW(raw), .SDO_O(sdo_o), .SDO_OE_N(sdo_oe_n), .CONVERTING(conv));
	asr_host asr_host_i (.clk(clk), .serial_data_out(sdo_line), .cs_n(cs_n), .sck(sck));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	// Length of the last finished conversion, so a late start still measures it whole
	always @(posedge clk) begin
		if (conv === 1'b1) begin
			conv_run <= conv_run + 1;
		end else begin
			if (conv_run != 0)
				conv_len_seen <= conv_run;
			conv_run <= 0;
		end
	end
	task automatic chk_bit(input string what, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %b seen %b", what, e, g);
		end
	endtask : chk_bit
	task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk_word
	task automatic do_reset();
		int k;
		k = 0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk_bit("conv_rst", 1'b0, conv);
		chk_bit("oe_rst", 1'b1, sdo_oe_n);
		while (conv !== 1'b1 && k < 300) begin
			@(posedge clk);
			k++;
		end
		chk_bit("por_len", 1'b1, k >= POR_N && k <= POR_N + 3);
	endtask : do_reset
	// Waits out a conversion and returns its full length, or -1 if none started within 300 cycles or it had not ended by the limit
	task automatic wait_conv(output int n);
		int   k;
		logic seen;
		k = 0;
		while (conv !== 1'b1 && k < 300) begin
			@(posedge clk);
			k++;
		end
		seen = (conv === 1'b1);
		while (conv === 1'b1 && k < CONV_N + 400) begin
			@(posedge clk);
			k++;
		end
		@(posedge clk);
		n = (seen && conv !== 1'b1) ? conv_len_seen : -1;
	endtask : wait_conv
	initial begin
		asr_row_t         r;
		logic [RES_W-1:0] w;
		int               n;
		do_reset();
		for (int i = 0; i < 6; i++) begin
			r = rows[i];
			raw <= r.raw;
			if (r.hi) begin
				asr_host_i.status();
				chk_bit("status_busy", 1'b1, sdo_line);
			end
			wait_conv(n);
			chk_word("conv_len", 16'(CONV_N), 16'(n));
			if (r.hi) begin
				repeat (5) @(posedge clk);
				chk_bit("status_done", 1'b0, sdo_line);
			end
			asr_host_i.xfer(r.hi, 16 + int'(r.hi & r.clk_end), r.clk_end, w);
			chk_word("result", r.exp, w);
			chk_bit("conv_by_clock", r.clk_end, conv);
			asr_host_i.release_cs();
			chk_bit("oe_released", 1'b1, sdo_oe_n);
		end
		raw <= 18'sh09234;
		wait_conv(n);
		asr_host_i.xfer(1'b0, 0, 1'b0, w);
		chk_bit("msb_only", 1'b1, sdo_line);
		raw <= 18'sh0BEEF;
		asr_host_i.release_cs();
		asr_host_i.xfer(1'b0, 3, 1'b1, w);
		chk_bit("no_abort", 1'b1, conv);
		asr_host_i.release_cs();
		wait_conv(n);
		chk_word("pulse_conv_len", 16'(CONV_N), 16'(n));
		raw <= 18'sh00077;
		repeat (400) @(posedge clk);
		asr_host_i.xfer(1'b1, 17, 1'b1, w);
		chk_word("held_result", 16'hBEEF, w);
		raw <= 18'sh0C3C3;
		asr_host_i.release_cs();
		wait_conv(n);
		asr_host_i.xfer(1'b1, 5, 1'b0, w);
		chk_word("partial", 16'h0018, w);
		asr_host_i.release_cs();
		wait_conv(n);
		chk_word("abort_conv_len", 16'(CONV_N), 16'(n));
		repeat (30) @(posedge clk);
		do_reset();
		raw <= 18'sh00ABC;
		wait_conv(n);
		asr_host_i.xfer(1'b0, 16, 1'b1, w);
		chk_word("first_after_por", 16'h0ABC, w);
		stop_test();
	end
endmodule : asr_sequencer_bench
`default_nettype wire
